// ### rtl/omv_path_dec.sv
// one mixer path: register fields decoded to registered route, gain and mute
`timescale 1ns/100ps
`default_nettype none
module omv_path_dec (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       reset_n,
   // register content
   input  wire logic [7:0] reg_val,
   // mixer side
   output var  logic       route_en,
   output var  logic [6:0] gain_idx,
   output var  logic [9:0] atten_tenths,
   output var  logic       mute
);
   import omv_pkg::*;

   logic       route_nxt;
   logic [6:0] idx_nxt;
   logic [9:0] att_nxt;
   logic       mute_nxt;

   // decode the stored code; mute codes keep their index but flag mute
   always_comb begin
      route_nxt = reg_val[OMV_ROUTE_BIT];
      idx_nxt   = reg_val[OMV_VOL_MSB:0];
      att_nxt   = omv_atten_f(reg_val[OMV_VOL_MSB:0]);
      mute_nxt  = (reg_val[OMV_VOL_MSB:0] > OMV_VOL_LAST);
   end

   // registered so the analog side sees glitch-free static levels
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         route_en     <= 1'b0;
         gain_idx     <= 7'h00;
         atten_tenths <= 10'h000;
         mute         <= 1'b0;
      end else begin
         route_en     <= route_nxt;
         gain_idx     <= idx_nxt;
         atten_tenths <= att_nxt;
         mute         <= mute_nxt;
      end
   end

   a_mute_decode: assert property (@(posedge mclk) disable iff (!reset_n)
      (reg_val[OMV_VOL_MSB:0] > 7'd117) |=> mute && atten_tenths == 10'h3FF)
      else $error("mute code did not mute the path");
   a_linear_step: assert property (@(posedge mclk) disable iff (!reset_n)
      (reg_val[OMV_VOL_MSB:0] <= 7'd36) |=> atten_tenths == 10'(gain_idx) * 10'd5 && !mute)
      else $error("linear code gave wrong attenuation");
   a_range_end: assert property (@(posedge mclk) disable iff (!reset_n)
      !mute |-> atten_tenths <= 10'd783)
      else $error("attenuation beyond range");
endmodule
`default_nettype wire

// ### rtl/omv_pkg.sv
// package: offsets, field layout, reset values and gain table constants for output mixer volume
package omv_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] OMV_LINE2_HPL_OFS  = 8'h2D;
   localparam logic [7:0] OMV_AMP_HPL_OFS    = 8'h2E;
   localparam int         OMV_NUM_PATHS      = 2;

   // ---------------------------------------------------------------
   // field layout and reset values
   // ---------------------------------------------------------------
   localparam int         OMV_ROUTE_BIT      = 7;
   localparam int         OMV_VOL_MSB        = 6;
   localparam logic [7:0] OMV_REG_RST        = 8'h00;
   localparam logic [6:0] OMV_VOL_LINEAR_MAX = 7'h24;  // code 36
   localparam logic [6:0] OMV_VOL_LAST       = 7'h75;  // code 117
   localparam logic [9:0] OMV_MUTE_ATTEN     = 10'h3FF;

   // attenuation in tenths of a dB for a gain code; mute codes give all ones
   function automatic logic [9:0] omv_atten_f(input logic [6:0] code);
      logic [9:0] a;
      a = 10'h000;
      if (code <= OMV_VOL_LINEAR_MAX) begin
         a = 10'(code) * 10'd5;
      end else if (code <= 7'd88) begin
         // 37..75 sit one tenth beyond the linear run, 76..86 two tenths;
         // a few table steps break the pattern and are listed
         case (code)
            7'd71: a = 10'd357;
            7'd73: a = 10'd367;
            7'd75: a = 10'd377;
            7'd87: a = 10'd438;
            7'd88: a = 10'd443;
            default: a = 10'(code) * 10'd5 + (code >= 7'd76 ? 10'd2 : 10'd1);
         endcase
      end else begin
         case (code)
            7'd89:  a = 10'd448;
            7'd90:  a = 10'd452;
            7'd91:  a = 10'd458;
            7'd92:  a = 10'd462;
            7'd93:  a = 10'd467;
            7'd94:  a = 10'd474;
            7'd95:  a = 10'd479;
            7'd96:  a = 10'd482;
            7'd97:  a = 10'd487;
            7'd98:  a = 10'd493;
            7'd99:  a = 10'd500;
            7'd100: a = 10'd503;
            7'd101: a = 10'd510;
            7'd102: a = 10'd514;
            7'd103: a = 10'd518;
            7'd104: a = 10'd522;
            7'd105: a = 10'd527;
            7'd106: a = 10'd537;
            7'd107: a = 10'd542;
            7'd108: a = 10'd553;
            7'd109: a = 10'd567;
            7'd110: a = 10'd583;
            7'd111: a = 10'd602;
            7'd112: a = 10'd627;
            7'd113: a = 10'd643;
            7'd114: a = 10'd662;
            7'd115: a = 10'd687;
            7'd116: a = 10'd722;
            7'd117: a = 10'd783;
            default: a = OMV_MUTE_ATTEN;
         endcase
      end
      return a;
   endfunction

endpackage

// ### rtl/omv_regs.sv
// top: register bank for left headphone mixer paths with decoded gain outputs
`timescale 1ns/100ps
`default_nettype none
module omv_regs (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       reset_n,
   // register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output var  logic [7:0] reg_rdata,
   // left line input two to left headphone output
   output var  logic       line2_route_en,
   output var  logic [6:0] line2_gain_idx,
   output var  logic [9:0] line2_atten_tenths,
   output var  logic       line2_mute,
   // left input amplifier to left headphone output
   output var  logic       amp_route_en,
   output var  logic [6:0] amp_gain_idx,
   output var  logic [9:0] amp_atten_tenths,
   output var  logic       amp_mute
);
   import omv_pkg::*;

   // ---------------------------------------------------------------
   // register storage, one entry per path
   // ---------------------------------------------------------------
   logic [7:0] vol_r   [OMV_NUM_PATHS];
   logic [7:0] vol_nxt [OMV_NUM_PATHS];
   logic [7:0] rdata_nxt;

   // address to path index; invalid addresses give no hit
   function automatic logic [1:0] omv_sel_f(input logic [7:0] a);
      logic [1:0] s;
      s = 2'b00;
      if (a == OMV_LINE2_HPL_OFS) begin
         s = 2'b01;
      end else if (a == OMV_AMP_HPL_OFS) begin
         s = 2'b11;
      end
      return s;   // bit 1 = index, bit 0 = hit
   endfunction

   // a write touches only its own path, so drivers never disturb each other
   always_comb begin
      logic [1:0] ws;
      logic [1:0] rs;
      ws = omv_sel_f(reg_addr);
      rs = ws;
      for (int i = 0; i < OMV_NUM_PATHS; i++) begin
         vol_nxt[i] = vol_r[i];
         if (reg_wr && ws[0] && (int'(ws[1]) == i)) begin
            vol_nxt[i] = reg_wdata;
         end
      end
      // unmapped reads answer zero
      rdata_nxt = 8'h00;
      if (reg_rd && rs[0]) begin
         rdata_nxt = vol_r[rs[1]];
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < OMV_NUM_PATHS; i++) begin
            vol_r[i] <= OMV_REG_RST;
         end
         reg_rdata <= 8'h00;
      end else begin
         for (int i = 0; i < OMV_NUM_PATHS; i++) begin
            vol_r[i] <= vol_nxt[i];
         end
         reg_rdata <= rdata_nxt;
      end
   end

   // ---------------------------------------------------------------
   // per-path decoders, one instance per volume control
   // ---------------------------------------------------------------
   omv_path_dec u_line2 (
      .mclk         (mclk),
      .reset_n      (reset_n),
      .reg_val      (vol_r[0]),
      .route_en     (line2_route_en),
      .gain_idx     (line2_gain_idx),
      .atten_tenths (line2_atten_tenths),
      .mute         (line2_mute)
   );

   omv_path_dec u_amp (
      .mclk         (mclk),
      .reset_n      (reset_n),
      .reg_val      (vol_r[1]),
      .route_en     (amp_route_en),
      .gain_idx     (amp_gain_idx),
      .atten_tenths (amp_atten_tenths),
      .mute         (amp_mute)
   );

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_write_line2;
      reg_wr && reg_addr == 8'h2D;
   endsequence

   a_write_route: assert property (@(posedge mclk) disable iff (!reset_n)
      s_write_line2 |-> ##2 line2_route_en == $past(reg_wdata[7], 2))
      else $error("route output did not follow write");
   a_write_isolated: assert property (@(posedge mclk) disable iff (!reset_n)
      s_write_line2 |=> $stable(vol_r[1]))
      else $error("write disturbed other path");
   a_read_back: assert property (@(posedge mclk) disable iff (!reset_n)
      (reg_rd && reg_addr == 8'h2E) |=> reg_rdata == $past(vol_r[1]))
      else $error("read data wrong");
   a_amp_gain: assert property (@(posedge mclk) disable iff (!reset_n)
      (reg_wr && reg_addr == 8'h2E) |-> ##2 amp_gain_idx == $past(reg_wdata[6:0], 2))
      else $error("amplifier gain did not follow write");
   a_amp_route: assert property (@(posedge mclk) disable iff (!reset_n)
      (reg_wr && reg_addr == 8'h2E) |-> ##2 amp_route_en == $past(reg_wdata[7], 2))
      else $error("amplifier route did not follow write");
   a_table_end: assert property (@(posedge mclk) disable iff (!reset_n)
      (reg_wr && reg_addr == 8'h2D && reg_wdata[6:0] == 7'd117)
      |-> ##2 line2_atten_tenths == 10'd783 && !line2_mute)
      else $error("code 117 not -78.3 dB");
endmodule
`default_nettype wire

// ### sim/omv_mix_model.sv
// far-side model: one mixer input as the headphone driver sees it
`timescale 1ns/100ps
`default_nettype none
module omv_mix_model (
   // path controls from the register bank
   input  wire logic       route_en,
   input  wire logic       mute,
   input  wire logic [9:0] atten_tenths,
   // loss seen by the driver, all ones when the source is cut off
   output var  logic [9:0] path_loss
);
   // an unrouted or muted source contributes nothing, whatever its code
   always_comb begin
      path_loss = (!route_en || mute) ? 10'h3FF : atten_tenths;
   end
endmodule
`default_nettype wire

// ### sim/omv_regs_tb_top.sv
// testbench: register access, gain decode and path isolation of the mixer bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
   $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module omv_regs_tb_top;
   import omv_pkg::*;
   logic       mclk, reset_n, reg_wr, reg_rd;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic       l_rt, l_mu, a_rt, a_mu;
   logic [6:0] l_gi, a_gi;
   logic [9:0] l_at, a_at, l_loss, a_loss;
   int         fails, n_compared;
   // sample codes across linear, tabulated and mute regions with their losses
   logic [6:0] cds[14] = '{7'h00, 7'h01, 7'h24, 7'h25, 7'h47, 7'h4C, 7'h56,
                           7'h58, 7'h59, 7'h6A, 7'h74, 7'h75, 7'h76, 7'h7F};
   logic [9:0] ats[14] = '{10'h000, 10'h005, 10'h0B4, 10'h0BA, 10'h165, 10'h17E,
                           10'h1B0, 10'h1BB, 10'h1C0, 10'h219, 10'h2D2, 10'h30F,
                           10'h3FF, 10'h3FF};
   omv_regs uut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .line2_route_en(l_rt), .line2_gain_idx(l_gi), .line2_atten_tenths(l_at),
      .line2_mute(l_mu), .amp_route_en(a_rt), .amp_gain_idx(a_gi),
      .amp_atten_tenths(a_at), .amp_mute(a_mu));
   omv_mix_model mix_l (.route_en(l_rt), .mute(l_mu), .atten_tenths(l_at), .path_loss(l_loss));
   omv_mix_model mix_a (.route_en(a_rt), .mute(a_mu), .atten_tenths(a_at), .path_loss(a_loss));
   // ----------------------------------------
   // bus tasks
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge mclk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   // path outputs follow one edge after the write edge; wait two spare
   task automatic settle();
      repeat (3) @(posedge mclk);
      #1;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_reset();
      `CHK({l_rt, l_gi, l_at, l_mu}, 19'h00000)
      `CHK({a_rt, a_gi, a_at, a_mu}, 19'h00000)
      rd(OMV_LINE2_HPL_OFS, d); `CHK(d, 8'h00)
      rd(OMV_AMP_HPL_OFS, d); `CHK(d, 8'h00)
   endtask
   // sweep the gain table on the line path, routing toggled; amp must not move
   task automatic test_line2_table();
      for (int i = 0; i < 14; i++) begin
         wr(OMV_LINE2_HPL_OFS, {i[0], cds[i]});
         settle();
         `CHK({l_rt, l_gi}, {i[0], cds[i]})
         `CHK(l_at, ats[i])
         `CHK(l_mu, (cds[i] >= 7'h76))
         `CHK(l_loss, (i[0] && cds[i] < 7'h76) ? ats[i] : 10'h3FF)
         `CHK({a_rt, a_gi, a_at, a_mu}, 19'h00000)
         rd(OMV_LINE2_HPL_OFS, d); `CHK(d, {i[0], cds[i]})
      end
   endtask
   task automatic test_amp_path();
      wr(OMV_AMP_HPL_OFS, 8'hF5);
      settle();
      `CHK({a_rt, a_gi, a_at, a_mu}, {1'b1, 7'h75, 10'h30F, 1'b0})
      `CHK({l_rt, l_gi}, 8'hFF)
      wr(OMV_AMP_HPL_OFS, 8'h76);
      settle();
      `CHK({a_rt, a_gi, a_mu, a_loss}, {1'b0, 7'h76, 1'b1, 10'h3FF})
   endtask
   // unmapped access, then a write followed at once by a read of the same place
   task automatic test_unmapped();
      wr(8'h2F, 8'hAA);
      rd(8'h2F, d); `CHK(d, 8'h00)
      rd(OMV_LINE2_HPL_OFS, d); `CHK(d, 8'hFF)
      @(posedge mclk);
      reg_wr <= 1'b1; reg_addr <= OMV_AMP_HPL_OFS; reg_wdata <= 8'h92;
      @(posedge mclk);
      reg_wr <= 1'b0; reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 `CHK(reg_rdata, 8'h92)
      @(posedge mclk);
      #1 `CHK(reg_rdata, 8'h00)
      settle();
      `CHK({a_rt, a_gi, a_at}, {1'b1, 7'h12, 10'h05A})
   endtask
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ----------------------------------------
   // clock, reset, sequence and watchdog
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      reset_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      #1;
      test_reset();
      test_line2_table();
      test_amp_path();
      test_unmapped();
      tally_and_finish();
   end
   // whole run is about 130 cycles; far beyond that means a hang
   initial begin
      #50000;
      fails++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
